// ### hdl/crtrt_pkg.sv
// Constants for the CRT raster and row refresh timing block.
// Assumes a single 20 MHz reference clock feeds every register.
package crtrt_pkg;

    // Reference clock and derived dot rate, both in kHz
    localparam int CLK_KHZ       = 20000;
    localparam int DOT_KHZ       = 11340;

    // Raster geometry in dots, characters, scan lines and rows
    localparam int DOTS_PER_CHAR = 7;
    localparam int CHARS_DISP    = 80;
    localparam int CHARS_TOTAL   = 100;
    localparam int LINES_PER_ROW = 10;
    localparam int ROWS_DISP     = 25;
    localparam int ROWS_TOTAL    = 27;
    localparam int SCREEN_CHARS  = 2000;

    // Horizontal drive stretch: nominal inside the 25 to 30 us window
    localparam int HDRIVE_NS     = 27500;
    localparam int HDRIVE_CYC    = (HDRIVE_NS * (CLK_KHZ / 1000) + 999) / 1000;

    // Length of the low phase of one row-fill strobe, in clock cycles
    localparam int STROBE_CYC    = 2;

    // Field widths
    localparam int ACC_W  = 15;
    localparam int COL_W  = 7;
    localparam int LINE_W = 4;
    localparam int ROW_W  = 5;
    localparam int ADDR_W = 11;
    localparam int HD_W   = 10;
    localparam int GLYPH_W = 7;
    localparam int RPT_W  = 8;

    // Row-fill engine states, Gray coded along idle, low, high
    typedef enum logic [1:0]
    {
        FILL_IDLE = 2'h0,
        FILL_LOW  = 2'h1,
        FILL_HIGH = 2'h3
    } crtrt_fill_t;

endpackage : crtrt_pkg

// ### hdl/crtrt_video_shift.sv
// Parallel-in serial-out dot shifter for one character slice.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/1ns
module crtrt_video_shift
(
    input  wire logic                            ref_clk,
    input  wire logic                            reset_n,
    input  wire logic                            load,
    input  wire logic                            shift,
    input  wire logic [crtrt_pkg::GLYPH_W-1:0]   par_in,
    output logic                                 video
);
    import crtrt_pkg::*;

    typedef struct packed
    {
        logic [GLYPH_W-1:0] sh;
    } crtrt_sh_state_t;

    crtrt_sh_state_t state_reg;
    crtrt_sh_state_t state_next;

    // Load beats shift so a boundary tick starts the new character
    always_comb
    begin
        state_next = state_reg;
        if (load)
            state_next.sh = par_in;
        else if (shift)
            state_next.sh = {state_reg.sh[GLYPH_W-2:0], 1'h0};
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign video = state_reg.sh[GLYPH_W-1];

    a_load_video: assert property (@(posedge ref_clk) disable iff (!reset_n)
        load |=> video == $past(par_in[GLYPH_W-1]))
        else $error("video does not show loaded leading dot");

endmodule : crtrt_video_shift

// ### hdl/crtrt_timing.sv
// Raster timing, drive pulses, frame and row-fill events for the display.
// Assumes cpu strobes and transfer select arrive as asynchronous pins;
// glyph_bits, first_line_addr and scan_ack come from the same clock.
`timescale 1ns/1ns

module crtrt_timing
#(
    parameter int HDRIVE_CYCLES = crtrt_pkg::HDRIVE_CYC
)
(
    input  wire logic                            ref_clk,
    input  wire logic                            reset_n,
    input  wire logic [crtrt_pkg::GLYPH_W-1:0]   glyph_bits,
    input  wire logic [crtrt_pkg::ADDR_W-1:0]    first_line_addr,
    input  wire logic                            scan_ack,
    input  wire logic                            cpu_rd_n,
    input  wire logic                            cpu_wr_n,
    input  wire logic                            xfer_select,
    output logic                                 dot_strobe,
    output logic                                 char_clk,
    output logic [crtrt_pkg::COL_W-1:0]          char_col,
    output logic [crtrt_pkg::LINE_W-1:0]         scan_line,
    output logic [crtrt_pkg::ROW_W-1:0]          char_row,
    output logic                                 horizontal_retrace_interval,
    output logic                                 vertical_retrace_interval,
    output logic                                 horizontal_drive,
    output logic                                 vertical_drive,
    output logic                                 video,
    output logic                                 frame_event_routine,
    output logic                                 row_fill_event,
    output logic                                 scan_request,
    output logic [crtrt_pkg::RPT_W-1:0]          repeat_count,
    output logic [crtrt_pkg::ADDR_W-1:0]         mem_addr,
    output logic                                 mem_rd_n,
    output logic                                 ctrl_rd_n,
    output logic                                 buffer_select_strobe_n,
    output logic                                 ctrl_wr_n
);
    import crtrt_pkg::*;

    // The drive counter is HD_W bits wide
    if (HDRIVE_CYCLES < 1 || HDRIVE_CYCLES >= (1 << HD_W))
    begin : g_bad_hdrive
        $error("HDRIVE_CYCLES out of range for drive counter");
    end

    typedef struct packed
    {
        logic [ACC_W-1:0]   acc;
        logic               dot_strobe;
        logic [2:0]         dot_cnt;
        logic               char_clk;
        logic [COL_W-1:0]   col;
        logic [LINE_W-1:0]  line;
        logic [ROW_W-1:0]   row;
        logic               load;
        logic [GLYPH_W-1:0] glyph;
        logic               hretrace;
        logic               vretrace;
        logic [HD_W-1:0]    hd_cnt;
        logic               hdrive;
        logic               frame_evt;
        logic               row_evt;
        logic               scan_req;
        logic [RPT_W-1:0]   rpt;
        logic [ADDR_W-1:0]  addr;
        logic [COL_W-1:0]   xfer_cnt;
        crtrt_fill_t        fill;
        logic [1:0]         strobe_cnt;
        logic               rd_s1;
        logic               rd_s2;
        logic               wr_s1;
        logic               wr_s2;
        logic               xsel_s1;
        logic               xsel_s2;
        logic               mem_rd_n;
        logic               ctrl_rd_n;
        logic               bs_n;
        logic               ctrl_wr_n;
    } crtrt_state_t;

    crtrt_state_t state_reg;
    crtrt_state_t state_next;

    // Next-state logic for the whole raster and fill engine
    always_comb
    begin
        logic [ACC_W:0] sum;
        logic           tick;
        logic           busy;
        logic           route;
        logic           src_n;
        sum = '0;
        tick = 1'h0;
        busy = 1'h0;
        route = 1'h0;
        src_n = 1'h1;
        state_next = state_reg;
        state_next.load = 1'h0;
        state_next.frame_evt = 1'h0;
        state_next.row_evt = 1'h0;

        // Pin synchronisers; only stage two is read by logic
        state_next.rd_s1 = cpu_rd_n;
        state_next.rd_s2 = state_reg.rd_s1;
        state_next.wr_s1 = cpu_wr_n;
        state_next.wr_s2 = state_reg.wr_s1;
        state_next.xsel_s1 = xfer_select;
        state_next.xsel_s2 = state_reg.xsel_s1;

        // Fractional divider: 11.34 MHz average, jitter of one clock
        sum = {1'h0, state_reg.acc} + (ACC_W+1)'(DOT_KHZ);
        tick = (sum >= (ACC_W+1)'(CLK_KHZ));
        state_next.acc = tick ? ACC_W'(sum - (ACC_W+1)'(CLK_KHZ))
                              : sum[ACC_W-1:0];
        state_next.dot_strobe = tick;

        // Character, line and row counters driven by the dot divider
        if (tick)
        begin
            if (state_reg.dot_cnt == 3'(DOTS_PER_CHAR - 1))
            begin
                state_next.dot_cnt = 3'h0;
                state_next.load = 1'h1;
                // Blank cells feed zeros so retrace shows no dots
                state_next.glyph = (state_reg.col < COL_W'(CHARS_DISP) &&
                    state_reg.row < ROW_W'(ROWS_DISP)) ? glyph_bits : '0;
                if (state_reg.col == COL_W'(CHARS_TOTAL - 1))
                begin
                    state_next.col = '0;
                    if (state_reg.line == LINE_W'(LINES_PER_ROW - 1))
                    begin
                        state_next.line = '0;
                        if (state_reg.row == ROW_W'(ROWS_TOTAL - 1))
                            state_next.row = '0;
                        else
                            state_next.row = state_reg.row + 5'h01;
                        state_next.frame_evt =
                            (state_next.row == ROW_W'(ROWS_DISP - 1));
                        // Fill ahead of each shown row; none before retrace
                        state_next.row_evt =
                            (state_next.row == ROW_W'(ROWS_TOTAL - 1)) ||
                            (state_next.row < ROW_W'(ROWS_DISP - 1));
                    end
                    else
                        state_next.line = state_reg.line + 4'h1;
                end
                else
                    state_next.col = state_reg.col + 7'h01;
            end
            else
                state_next.dot_cnt = state_reg.dot_cnt + 3'h1;
        end
        state_next.char_clk = (state_next.dot_cnt < 3'h4);
        state_next.hretrace = (state_next.col >= COL_W'(CHARS_DISP));
        state_next.vretrace = (state_next.row >= ROW_W'(ROWS_DISP));

        // The retrace alone is too short for the monitor; stretch it
        if (state_next.load && state_next.col == COL_W'(CHARS_DISP))
        begin
            state_next.hd_cnt = HD_W'(HDRIVE_CYCLES);
            state_next.hdrive = 1'h1;
        end
        else if (state_reg.hd_cnt != '0)
        begin
            state_next.hd_cnt = state_reg.hd_cnt - 10'h001;
            state_next.hdrive = (state_next.hd_cnt != '0);
        end

        // Frame event: scan flag set wins over acknowledge
        if (state_next.frame_evt)
        begin
            state_next.scan_req = 1'h1;
            state_next.rpt = state_reg.rpt + 8'h01;
            state_next.addr = first_line_addr;
        end
        else if (scan_ack)
            state_next.scan_req = 1'h0;

        // Row-fill engine: low strobe reads memory and writes buffer
        case (state_reg.fill)
            FILL_IDLE:
            begin
                if (state_next.row_evt)
                begin
                    state_next.fill = FILL_LOW;
                    state_next.xfer_cnt = '0;
                    state_next.strobe_cnt = '0;
                end
            end
            FILL_LOW:
            begin
                if (state_reg.strobe_cnt == 2'(STROBE_CYC - 1))
                begin
                    state_next.fill = FILL_HIGH;
                    state_next.addr =
                        (state_reg.addr == ADDR_W'(SCREEN_CHARS - 1)) ? '0
                        : state_reg.addr + 11'h001;
                end
                else
                    state_next.strobe_cnt = state_reg.strobe_cnt + 2'h1;
            end
            FILL_HIGH:
            begin
                state_next.strobe_cnt = '0;
                if (state_reg.xfer_cnt == COL_W'(CHARS_DISP - 1))
                    state_next.fill = FILL_IDLE;
                else
                begin
                    state_next.xfer_cnt = state_reg.xfer_cnt + 7'h01;
                    state_next.fill = FILL_LOW;
                end
            end
            default:
                state_next.fill = FILL_IDLE;
        endcase

        // Strobe routing: engine acts as if transfer select were high
        busy = (state_next.fill != FILL_IDLE);
        route = busy || state_reg.xsel_s2;
        src_n = busy ? (state_next.fill != FILL_LOW) : state_reg.rd_s2;
        state_next.mem_rd_n = src_n;
        state_next.ctrl_rd_n = route ? 1'h1 : state_reg.rd_s2;
        state_next.bs_n = route ? src_n : 1'h1;
        state_next.ctrl_wr_n = route ? src_n : state_reg.wr_s2;
    end

    // Active-low strobes and idle pins rest high out of reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
            state_reg.rd_s1 <= 1'h1;
            state_reg.rd_s2 <= 1'h1;
            state_reg.wr_s1 <= 1'h1;
            state_reg.wr_s2 <= 1'h1;
            state_reg.mem_rd_n <= 1'h1;
            state_reg.ctrl_rd_n <= 1'h1;
            state_reg.bs_n <= 1'h1;
            state_reg.ctrl_wr_n <= 1'h1;
        end
        else
            state_reg <= state_next;
    end

    crtrt_video_shift u_shift
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .load    (state_reg.load),
        .shift   (state_reg.dot_strobe),
        .par_in  (state_reg.glyph),
        .video   (video)
    );

    assign dot_strobe = state_reg.dot_strobe;
    assign char_clk = state_reg.char_clk;
    assign char_col = state_reg.col;
    assign scan_line = state_reg.line;
    assign char_row = state_reg.row;
    assign horizontal_retrace_interval = state_reg.hretrace;
    assign vertical_retrace_interval = state_reg.vretrace;
    assign horizontal_drive = state_reg.hdrive;
    assign vertical_drive = state_reg.vretrace;
    assign frame_event_routine = state_reg.frame_evt;
    assign row_fill_event = state_reg.row_evt;
    assign scan_request = state_reg.scan_req;
    assign repeat_count = state_reg.rpt;
    assign mem_addr = state_reg.addr;
    assign mem_rd_n = state_reg.mem_rd_n;
    assign ctrl_rd_n = state_reg.ctrl_rd_n;
    assign buffer_select_strobe_n = state_reg.bs_n;
    assign ctrl_wr_n = state_reg.ctrl_wr_n;

    // Helper: length of the current horizontal drive pulse
    logic [HD_W:0] hd_len_reg;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            hd_len_reg <= '0;
        else
            hd_len_reg <= state_reg.hdrive ? hd_len_reg + 11'h001 : '0;
    end

    // The divider starts empty, so its first gap after reset is two clocks
    a_dot_no_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !dot_strobe && $past(reset_n) |=> dot_strobe)
        else $error("dot strobe missing two clocks in a row");
    a_char_div: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg.load |-> state_reg.dot_cnt == 3'h0 && dot_strobe)
        else $error("character load off the dot boundary");
    a_hdrive_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(horizontal_drive) |-> hd_len_reg == (HD_W+1)'(HDRIVE_CYCLES))
        else $error("horizontal drive width wrong");
    a_hretrace_cols: assert property (@(posedge ref_clk) disable iff (!reset_n)
        horizontal_retrace_interval == (char_col >= COL_W'(CHARS_DISP)))
        else $error("horizontal retrace not on columns 80 to 99");
    a_vdrive_rows: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vertical_drive == (char_row >= ROW_W'(ROWS_DISP))
        && char_row < ROW_W'(ROWS_TOTAL)
        && scan_line < LINE_W'(LINES_PER_ROW))
        else $error("vertical retrace rows wrong");
    a_frame_row: assert property (@(posedge ref_clk) disable iff (!reset_n)
        frame_event_routine |-> char_row == ROW_W'(ROWS_DISP - 1)
        && mem_addr == $past(first_line_addr))
        else $error("frame event outside last row or no rewind");
    a_frame_scan: assert property (@(posedge ref_clk) disable iff (!reset_n)
        frame_event_routine |-> scan_request
        && repeat_count == $past(repeat_count) + 8'h01)
        else $error("frame event did not flag scan or count");
    a_fill_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
        row_fill_event |-> ##[239:242] state_reg.fill == FILL_IDLE)
        else $error("row fill did not end in time");
    a_fill_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(mem_rd_n) && state_reg.fill == FILL_HIGH
        |-> mem_addr != $past(mem_addr, 2))
        else $error("address did not advance after transfer");
    a_bs_with_wr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !buffer_select_strobe_n |-> !ctrl_wr_n && !mem_rd_n && ctrl_rd_n)
        else $error("buffer strobe not paired with write and read");

endmodule : crtrt_timing

// ### verification/crtrt_monitor_model.sv
// Behavioural model of the monitor's horizontal and vertical drive inputs.
// Assumes both drives are clean levels synchronous to ref_clk.
`timescale 1ns/1ns
module crtrt_monitor_model
(
    input  wire logic ref_clk,
    input  wire logic horizontal_drive,
    input  wire logic vertical_drive,
    output int        hd_width,
    output int        hd_period,
    output int        hd_count,
    output int        vd_width
);
    int   hd_run;
    int   hd_gap;
    int   vd_run;
    logic hd_last;
    logic vd_last;

    initial
    begin
        {hd_width, hd_period, hd_count, vd_width} = '0;
        {hd_run, hd_gap, vd_run} = '0;
        {hd_last, vd_last} = 2'h0;
    end

    // Deflection only sees widths and spacing, so measure those in clocks
    always @(posedge ref_clk)
    begin
        hd_gap++;
        if (horizontal_drive && !hd_last)
        begin
            hd_period = hd_gap;   // Rise to rise sets the line rate
            hd_gap    = 0;
            hd_count++;
        end
        if (!horizontal_drive && hd_last)
            hd_width = hd_run;   // Clocks the pulse was seen high
        hd_run = horizontal_drive ? hd_run + 1 : 0;
        vd_run = vertical_drive ? vd_run + 1 : vd_run;
        if (!vertical_drive && vd_last)
            vd_width = vd_run;
        if (!vertical_drive)
            vd_run = 0;
        hd_last = horizontal_drive;
        vd_last = vertical_drive;
    end
endmodule : crtrt_monitor_model

// ### verification/crtrt_timing_tb.sv
// Self-checking bench for the raster timing and row-fill block.
// Assumes the monitor model file is compiled before this one.
`timescale 1ns/1ns
module crtrt_timing_tb;
    import crtrt_pkg::*;
    logic               ref_clk, reset_n, scan_ack;
    logic               cpu_rd_n, cpu_wr_n, xfer_select;
    logic [GLYPH_W-1:0] glyph_bits;
    logic [ADDR_W-1:0]  first_line_addr, mem_addr;
    logic               dot_strobe, char_clk, video, row_fill_event;
    logic [COL_W-1:0]   char_col;
    logic [LINE_W-1:0]  scan_line;
    logic [ROW_W-1:0]   char_row;
    logic               horizontal_retrace_interval, vertical_retrace_interval;
    logic               horizontal_drive, vertical_drive;
    logic               frame_event_routine, scan_request;
    logic [RPT_W-1:0]   repeat_count;
    logic               mem_rd_n, ctrl_rd_n, buffer_select_strobe_n, ctrl_wr_n;
    logic [31:0]        dot_total;
    int                 hd_width, hd_period, hd_count;
    int                 n_mismatch = 0;
    int                 n_tests    = 0;

    crtrt_timing #(.HDRIVE_CYCLES(HDRIVE_CYC)) dut_u
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .glyph_bits(glyph_bits),
        .first_line_addr(first_line_addr), .scan_ack(scan_ack),
        .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n), .xfer_select(xfer_select),
        .dot_strobe(dot_strobe), .char_clk(char_clk), .char_col(char_col),
        .scan_line(scan_line), .char_row(char_row),
        .horizontal_retrace_interval(horizontal_retrace_interval),
        .vertical_retrace_interval(vertical_retrace_interval),
        .horizontal_drive(horizontal_drive), .vertical_drive(vertical_drive),
        .video(video), .frame_event_routine(frame_event_routine),
        .row_fill_event(row_fill_event), .scan_request(scan_request),
        .repeat_count(repeat_count), .mem_addr(mem_addr),
        .mem_rd_n(mem_rd_n), .ctrl_rd_n(ctrl_rd_n),
        .buffer_select_strobe_n(buffer_select_strobe_n), .ctrl_wr_n(ctrl_wr_n)
    );

    crtrt_monitor_model mon_u
    (
        .ref_clk(ref_clk), .horizontal_drive(horizontal_drive),
        .vertical_drive(vertical_drive), .hd_width(hd_width),
        .hd_period(hd_period), .hd_count(hd_count), .vd_width()
    );

    // 20 MHz reference clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Running dot count, so spans can be measured in dots, not jittery clocks
    always @(posedge ref_clk or negedge reset_n)
        if (!reset_n) dot_total <= 32'h0;
        else          dot_total <= dot_total + 32'(dot_strobe);

    task automatic check_val(input string w, input logic [31:0] e,
                             input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("mismatch %s expected %0h seen %0h", w, e, g);
            n_mismatch++;
        end
    endtask : check_val

    task automatic check_range(input string w, input int lo, input int hi,
                               input logic [31:0] g);
        n_tests++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, g);
            n_mismatch++;
        end
    endtask : check_range

    task automatic close_out;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Wait for char_col to arrive at c afresh; each loop bounded to 2000 clocks, over a line and a half
    task automatic wait_col(input logic [COL_W-1:0] c);
        for (int k = 0; k < 2000 && char_col === c; k++) @(negedge ref_clk);
        for (int k = 0; k < 2000 && char_col !== c; k++) @(negedge ref_clk);
    endtask : wait_col

    task automatic t_reset;
        check_val("reset strobes", 4'hf, {mem_rd_n, ctrl_rd_n,
                  buffer_select_strobe_n, ctrl_wr_n});
        check_val("reset counters", 32'h0, {char_col, scan_line, char_row});
        check_val("reset drives", 3'h0, {horizontal_drive, video, mem_addr[0]});
    endtask : t_reset

    task automatic t_line;
        int          cyc, rises, bad;
        logic [31:0] d0;
        logic [3:0]  l0;
        logic        pc;
        rises = 0;
        bad   = 0;
        wait_col(7'h0);
        d0 = dot_total;
        l0 = scan_line;
        pc = char_clk;
        for (cyc = 0; cyc < 1300; cyc++)
        begin
            if (cyc > 20 && char_col === 7'h0) break;
            if (horizontal_retrace_interval !== (char_col >= 7'd80)) bad++;
            @(negedge ref_clk);
            if (char_clk && !pc) rises++;
            pc = char_clk;
        end
        check_val("dots per line", 32'd700, dot_total - d0);
        check_val("char clocks per line", 32'd100, rises);
        check_val("retrace vs column", 32'd0, bad);
        check_range("clocks per line", 1234, 1235, cyc);
        check_val("next scan line", (l0 == 4'd9) ? 0 : l0 + 1, scan_line);
    endtask : t_line

    task automatic t_video;
        logic [6:0]  w, rot;
        logic [13:0] dd;
        int          n, ok, ones;
        n = 0;
        ok = 0;
        ones = 0;
        dd = {7'h68, 7'h68};
        wait_col(7'd20);
        while (n < 7)
        begin
            @(negedge ref_clk);
            if (dot_strobe)
            begin
                w = {w[5:0], video};
                n++;
            end
        end
        for (int r = 0; r < 7; r++)
        begin
            rot = 7'(dd >> r);
            if (w === rot) ok = 1;
        end
        check_val("video slice order", 32'd1, ok);
        wait_col(7'd90);
        repeat (20) @(negedge ref_clk) ones += int'(video !== 1'b0);
        check_val("video in retrace", 32'd0, ones);
    endtask : t_video

    task automatic t_hdrive;
        wait_col(7'd80);
        check_val("hdrive at col 80", 32'd1, horizontal_drive);
        wait_col(7'd60);
        check_val("hdrive width", HDRIVE_CYC, hd_width);
        check_val("hdrive pulses", 32'd4, hd_count);
        check_range("hdrive 25 to 30 us", 500, 600, hd_width);
        check_range("line period", 1234, 1235, hd_period);
        check_range("line rate window", 1231, 1311, hd_period);
    endtask : t_hdrive

    task automatic t_fill;
        logic [ADDR_W-1:0] a0;
        logic [31:0]       d0;
        logic [2:0]        tbl [3];
        logic [3:0]        exp [3];
        int                lows, falls, last, bad, k;
        logic              pv;
        {lows, falls, last, bad} = '0;
        pv = 1'b1;
        tbl = '{3'b001, 3'b101, 3'b110};   // xfer, rd_n, wr_n
        exp = '{4'b0110, 4'b1000, 4'b1111}; // rd, bs, wr, mem
        for (k = 0; k < 14000 && row_fill_event !== 1'b1; k++)
            @(negedge ref_clk);
        check_val("fill at row start", 32'h0, {char_col, scan_line});
        a0 = mem_addr;
        d0 = dot_total;
        cpu_wr_n = 1'b0;   // Must not leak onto the controller while busy
        // Strobes fall on the event's own edge, so sample before waiting
        for (k = 0; k < 300; k++)
        begin
            if (k == 240) cpu_wr_n = 1'b1;
            if (k < 240 && (buffer_select_strobe_n !== mem_rd_n ||
                            ctrl_wr_n !== mem_rd_n)) bad++;
            if (!mem_rd_n)
            begin
                lows++;
                last = k;
            end
            if (pv && !mem_rd_n) falls++;
            pv = mem_rd_n;
            @(negedge ref_clk);
        end
        check_val("fill transfers", 32'd80, falls);
        check_val("fill low cycles", 32'd160, lows);
        check_val("strobes move together", 32'd0, bad);
        check_range("fill within row", 1, 12700, last);
        check_val("fill address", (a0 + 80) % 2000, mem_addr);
        for (int i = 0; i < 3; i++)
        begin
            {xfer_select, cpu_rd_n, cpu_wr_n} = tbl[i];
            repeat (3) @(negedge ref_clk);
            check_val("pass-through strobes", exp[i], {ctrl_rd_n,
                      buffer_select_strobe_n, ctrl_wr_n, mem_rd_n});
        end
        {xfer_select, cpu_rd_n, cpu_wr_n} = 3'b011;
        for (k = 0; k < 14000 && row_fill_event !== 1'b1; k++)
            @(negedge ref_clk);
        check_val("dots between fills", 32'd7000, dot_total - d0);
        check_val("row after two fills", 32'd2, char_row);
        check_val("no frame event yet", 32'h0, {scan_request, repeat_count,
                  vertical_drive, vertical_retrace_interval,
                  frame_event_routine});
    endtask : t_fill

    // Watchdog: the whole sequence needs about two character rows
    initial
    begin
        repeat (40000) @(negedge ref_clk);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        reset_n = 1'b0;
        glyph_bits = 7'h68;
        first_line_addr = 11'h000;
        {scan_ack, cpu_rd_n, cpu_wr_n, xfer_select} = 4'h6;
        repeat (2) @(negedge ref_clk);
        t_reset();
        reset_n = 1'b1;
        t_line();
        t_video();
        t_hdrive();
        t_fill();
        close_out();
    end
endmodule : crtrt_timing_tb
